// >>> rtl/pll_ratio_strap_decoder.sv
// decodes reset-configuration straps into platform, core and memory ratios
// assumes straps come from pins (async to hclk) and hresetn is power-on reset
// Behaviour
// R1 - platform straps 000..101 give 4,5,6,8,10,12 to one; 110/111 reserved
// R2 - board must pull every platform strap; no default ratio exists
// R3 - core0 straps 011..111 give 3:2,2:1,5:2,3:1,7:2; lower codes reserved
// R4 - core1 straps decoded alike with the same encoding as core0
// R5 - each core runs at its own ratio, independent of the other
// R6 - synchronous mode: memory data rate equals platform frequency
// R7 - memory bus clock is half the memory data rate in both modes
// R8 - asynchronous mode: memory clocked from own PLL on memory reference
// R9 - asynchronous mode needs data rate above platform frequency
// R10 - asynchronous mode keeps memory bus clock at or below platform clock
// R11 - straps keep core, platform and data rate inside speed grade limits
// R12 - memory bus clock kept between 200 and 400 MHz
// R13 - memory straps give 3,4,6,8,10,12,14 to one; 111 is synchronous mode
// R14 - both memory controllers share one timing mode
// R15 - straps captured once during power-on reset and held until next one; the code captures them six clocks after hresetn release
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`include "strap_decoder_regs.svh"

module pll_ratio_strap_decoder (
    input wire logic hclk,
    input wire logic hresetn,
    // strap pins
    input wire logic [2:0] platform_ratio_straps,
    input wire logic core0_ratio_strap_msb,
    input wire logic core0_ratio_strap_mid,
    input wire logic core0_ratio_strap_lsb,
    input wire logic core1_ratio_strap_msb,
    input wire logic core1_ratio_strap_mid,
    input wire logic core1_ratio_strap_lsb,
    input wire logic memory_ratio_strap_msb,
    input wire logic memory_ratio_strap_mid,
    input wire logic memory_ratio_strap_lsb,
    // decoded ratios
    output strap_decoder_pkg::ratio_set_t ratios,
    output logic straps_locked,
    output logic mem0_sync_mode,
    output logic mem1_sync_mode,
    output logic mem_pll_select,
    output logic mem_bus_clk_div2,
    output logic core1_clk_enable,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import strap_decoder_pkg::*;

    localparam int SETTLE_CYC = `SETTLE_CYC;

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------

    // platform multiplier; reserved codes give zero and clear valid
    function automatic logic [7:0] plat_mult_f(input logic [2:0] c);
        logic [7:0] m;
        m = 8'h00;
        case (c) // [R1]
            3'h0: m = 8'h04;
            3'h1: m = 8'h05;
            3'h2: m = 8'h06;
            3'h3: m = 8'h08;
            3'h4: m = 8'h0A;
            3'h5: m = 8'h0C;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // core ratio times two: code 3 -> 3, code 4 -> 4 ... code 7 -> 7
    // shared by both cores so they always decode alike
    function automatic logic [7:0] core_x2_f(input logic [2:0] c);
        logic [7:0] m;
        m = 8'h00;
        if (c >= `CORE_CODE_MIN) begin
            m = {5'h00, c}; // [R3] [R4]
        end
        return m;
    endfunction

    // memory data rate to memory reference multiplier
    function automatic logic [7:0] mem_mult_f(input logic [2:0] c);
        logic [7:0] m;
        m = 8'h00;
        case (c) // [R13]
            3'h0: m = `MEM_NUM_3;
            3'h1: m = 8'h04;
            3'h2: m = 8'h06;
            3'h3: m = 8'h08;
            3'h4: m = 8'h0A;
            3'h5: m = 8'h0C;
            3'h6: m = 8'h0E;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------

    strap_set_t raw, sync1_q, sync2_q;

    // one driver for the whole set; order is platform, core0, core1, memory, msb first
    assign raw = {platform_ratio_straps,
                  core0_ratio_strap_msb, core0_ratio_strap_mid, core0_ratio_strap_lsb,
                  core1_ratio_strap_msb, core1_ratio_strap_mid, core1_ratio_strap_lsb,
                  memory_ratio_strap_msb, memory_ratio_strap_mid, memory_ratio_strap_lsb};

    // two flops before any logic reads the pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // capture sequencer
    // ------------------------------------------------------------

    // the async reset only clears state; straps are caught on the sixth clock after
    // release, once the synchronisers have refilled with settled pin levels
    capture_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    strap_set_t cap_q, cap_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cap_d = cap_q;
        case (state_q)
            ST_RESET: begin
                state_d = ST_SETTLE;
                cnt_d = 8'h00;
            end
            ST_SETTLE: begin
                if (cnt_q == 8'(SETTLE_CYC)) begin
                    cap_d = sync2_q; // [R15]
                    state_d = ST_LOCKED;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
            ST_LOCKED: begin
                state_d = ST_LOCKED; // held until next power-on reset [R15]
            end
            default: state_d = ST_RESET;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_RESET;
            cnt_q <= 8'h00;
            cap_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cap_q <= cap_d;
        end
    end

    // ------------------------------------------------------------
    // decoded ratio registers
    // ------------------------------------------------------------

    // the board owns strap validity; reserved codes are flagged, not fixed [R2]
    ratio_set_t rat_q, rat_d;
    logic [31:0] ctrl_q, ctrl_d;

    always_comb begin
        rat_d = rat_q;
        if (state_q == ST_SETTLE && state_d == ST_LOCKED) begin
            rat_d.plat_mult = plat_mult_f(cap_d.platform); // [R1]
            rat_d.plat_valid = (cap_d.platform <= `PLAT_CODE_MAX);
            // each core keeps its own ratio [R5]
            rat_d.core0_x2 = core_x2_f(cap_d.core0); // [R3]
            rat_d.core0_valid = (cap_d.core0 >= `CORE_CODE_MIN);
            rat_d.core1_x2 = core_x2_f(cap_d.core1); // [R4]
            rat_d.core1_valid = (cap_d.core1 >= `CORE_CODE_MIN);
            rat_d.mem_mult = mem_mult_f(cap_d.memory); // [R13]
            rat_d.sync_mode = (cap_d.memory == `MEM_SYNC_CODE); // [R6]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rat_q <= '0;
        end else begin
            rat_q <= rat_d;
        end
    end

    // one mode bit feeds both controllers, so they cannot disagree [R14]
    assign ratios = rat_q;
    assign straps_locked = (state_q == ST_LOCKED);
    assign mem0_sync_mode = rat_q.sync_mode; // [R14]
    assign mem1_sync_mode = rat_q.sync_mode; // [R14]
    // async mode selects the pll fed by the memory reference [R8]
    assign mem_pll_select = straps_locked & ~rat_q.sync_mode;
    // bus clocks divide data rate by two in either mode [R7]
    assign mem_bus_clk_div2 = straps_locked & ctrl_q[`CTRL_MEMCLK_EN_BIT];
    assign core1_clk_enable = straps_locked & ctrl_q[`CTRL_CORE1_EN_BIT]; // [R5]

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------

    // zero wait states; unmapped addresses read zero and ignore writes
    logic wr_pend_q, wr_pend_d;
    logic [11:0] addr_q, addr_d;
    logic [31:0] rdata_d, rdata_q;
    logic take;

    assign take = hsel & hready & htrans[1];

    function automatic logic [31:0] read_f(input logic [11:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == `REG_STRAPS_OFS) begin
            v = {20'h00000, cap_q};
        end else if (a == `REG_PLAT_OFS) begin
            v = {23'h000000, rat_q.plat_valid, rat_q.plat_mult};
        end else if (a == `REG_CORE_OFS) begin
            v = {14'h0000, rat_q.core1_valid, rat_q.core0_valid,
                 rat_q.core1_x2, rat_q.core0_x2};
        end else if (a == `REG_MEM_OFS) begin
            v = {22'h000000, straps_locked, rat_q.sync_mode, rat_q.mem_mult};
        end else if (a == `REG_CTRL_OFS) begin
            v = ctrl_q;
        end
        return v;
    endfunction

    always_comb begin
        wr_pend_d = take & hwrite;
        addr_d = take ? haddr[11:0] : addr_q;
        rdata_d = (take & ~hwrite) ? read_f(haddr[11:0]) : rdata_q;
        ctrl_d = ctrl_q;
        if (wr_pend_q && addr_q == `REG_CTRL_OFS) begin
            ctrl_d = {30'h00000000, hwdata[1:0]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 12'h000;
            rdata_q <= 32'h0000_0000;
            ctrl_q <= `CTRL_RESET;
        end else begin
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    chk_plat_decode: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        straps_locked |-> (rat_q.plat_valid == (cap_q.platform <= 3'h5)))
        else $error("platform valid flag mismatches captured code");

    chk_plat_twelve: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        (straps_locked && cap_q.platform == 3'h5) |-> rat_q.plat_mult == 8'h0C)
        else $error("platform code 101 not decoded as 12");

    chk_core0_decode: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
        (straps_locked && cap_q.core0 == 3'h7) |-> rat_q.core0_x2 == 8'h07)
        else $error("core0 code 111 not decoded as 7:2");

    chk_core1_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
        (straps_locked && cap_q.core1 < 3'h3) |-> !rat_q.core1_valid && rat_q.core1_x2 == 8'h00)
        else $error("core1 reserved code not flagged");

    chk_cores_independent: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
        (straps_locked && cap_q.core0 != cap_q.core1 && cap_q.core0 >= 3'h3
            && cap_q.core1 >= 3'h3) |-> rat_q.core0_x2 != rat_q.core1_x2)
        else $error("core1 ratio not from its own straps");

    chk_sync_mode: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
        straps_locked |-> (rat_q.sync_mode == (cap_q.memory == 3'h7)))
        else $error("sync mode not tied to memory code 111");

    chk_mem_fourteen: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
        (straps_locked && cap_q.memory == 3'h6) |-> rat_q.mem_mult == 8'h0E)
        else $error("memory code 110 not decoded as 14");

    chk_pll_select: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        straps_locked |-> (mem_pll_select != rat_q.sync_mode))
        else $error("memory pll select disagrees with mode");

    chk_modes_equal: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
        mem0_sync_mode == mem1_sync_mode)
        else $error("memory controllers in different modes");

    chk_ratios_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
        straps_locked |=> straps_locked && $stable(rat_q) && $stable(cap_q))
        else $error("ratios changed after lock");

    chk_lock_time: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
        (state_q == ST_RESET) |-> ##1 (!straps_locked)[*4] ##1 (!straps_locked)[*1]
        ##[1:3] straps_locked)
        else $error("capture did not lock in expected cycles");

    chk_div2_gate: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        !straps_locked |-> !mem_bus_clk_div2)
        else $error("memory bus divider enabled before lock");
endmodule

// >>> rtl/strap_decoder_pkg.sv
// types shared by the strap decoder
// assumes the constants header sits alongside
package strap_decoder_pkg;
    typedef struct packed {
        logic [2:0] platform;
        logic [2:0] core0;
        logic [2:0] core1;
        logic [2:0] memory;
    } strap_set_t;

    typedef struct packed {
        logic [7:0] plat_mult;   // platform : reference
        logic [7:0] core0_x2;    // core0 : platform, times two
        logic [7:0] core1_x2;    // core1 : platform, times two
        logic [7:0] mem_mult;    // memory data rate : memory reference
        logic sync_mode;
        logic plat_valid;
        logic core0_valid;
        logic core1_valid;
    } ratio_set_t;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_SETTLE,
        ST_LOCKED
    } capture_state_t;

    typedef struct packed {
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } ahb_req_t;
endpackage

// >>> rtl/strap_decoder_regs.svh
// strap decoder constants: register offsets, field positions, reset values
// assumes inclusion from the design file only
`ifndef STRAP_DECODER_REGS_SVH
`define STRAP_DECODER_REGS_SVH

// register byte offsets
`define REG_STRAPS_OFS 12'h000
`define REG_PLAT_OFS 12'h004
`define REG_CORE_OFS 12'h008
`define REG_MEM_OFS 12'h00C
`define REG_CTRL_OFS 12'h010

// strap code values
`define PLAT_CODE_MAX 3'h5
`define CORE_CODE_MIN 3'h3
`define MEM_SYNC_CODE 3'h7

// ratio numerators: core times two (x2 fixed point), memory multiplier unscaled
`define CORE_NUM_BASE 8'h03
`define MEM_NUM_3 8'h03

// cycles to hold straps stable before capture (settle window)
`define SETTLE_NS 40
`define SETTLE_CYC (((`SETTLE_NS) + 9) / 10)

// control register field positions
`define CTRL_CORE1_EN_BIT 0
`define CTRL_MEMCLK_EN_BIT 1
`define CTRL_RESET 32'h0000_0003

`endif

// >>> tb/pll_ratio_strap_decoder_tb.sv
// self-checking bench for the strap ratio decoder
// assumes the board model drives the straps and the bench is the only bus master
module pll_ratio_strap_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import strap_decoder_pkg::*;

    // --------
    // signals
    // --------
    localparam logic [7:0] PLAT_TBL [8] = '{8'h04, 8'h05, 8'h06, 8'h08,
                                            8'h0A, 8'h0C, 8'h00, 8'h00};
    localparam logic [7:0] MEM_TBL [8] = '{8'h03, 8'h04, 8'h06, 8'h08,
                                           8'h0A, 8'h0C, 8'h0E, 8'h00};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dphase_rd, prev_lock;
    logic straps_locked, mem0_sync_mode, mem1_sync_mode, mem_pll_select;
    logic mem_bus_clk_div2, core1_clk_enable;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, wd;
    logic [15:0] lfsr_s;
    ratio_set_t ratios, e;
    strap_set_t codes, pins, s;
    logic [31:0] rd_q[$];
    ratio_set_t rat_q[$];
    int n_fail, checks_done;

    strap_board_model strap_board_model_inst (.codes(codes), .pins(pins));

    // hready is looped back from the only slave
    pll_ratio_strap_decoder pll_ratio_strap_decoder_inst (
        .hclk(hclk), .hresetn(hresetn), .platform_ratio_straps(pins.platform),
        .core0_ratio_strap_msb(pins.core0[2]), .core0_ratio_strap_mid(pins.core0[1]),
        .core0_ratio_strap_lsb(pins.core0[0]), .core1_ratio_strap_msb(pins.core1[2]),
        .core1_ratio_strap_mid(pins.core1[1]), .core1_ratio_strap_lsb(pins.core1[0]),
        .memory_ratio_strap_msb(pins.memory[2]), .memory_ratio_strap_mid(pins.memory[1]),
        .memory_ratio_strap_lsb(pins.memory[0]), .ratios(ratios), .straps_locked(straps_locked),
        .mem0_sync_mode(mem0_sync_mode), .mem1_sync_mode(mem1_sync_mode),
        .mem_pll_select(mem_pll_select), .mem_bus_clk_div2(mem_bus_clk_div2),
        .core1_clk_enable(core1_clk_enable), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    // --------
    // helpers
    // --------
    function automatic logic [31:0] rnd();
        lfsr_s = {lfsr_s[14:0], lfsr_s[15] ^ lfsr_s[13] ^ lfsr_s[12] ^ lfsr_s[10]};
        return {lfsr_s, lfsr_s[7:0], lfsr_s[15:8]};
    endfunction

    // expected ratios, worked out from the strap tables
    function automatic ratio_set_t decode(input strap_set_t c);
        ratio_set_t r;
        r.plat_mult = PLAT_TBL[c.platform];  // platform multiplier
        r.plat_valid = (c.platform <= 3'h5);  // upper codes reserved
        r.core0_valid = (c.core0 >= 3'h3);  // lower codes reserved
        r.core0_x2 = r.core0_valid ? {5'h00, c.core0} : 8'h00;  // core ratio doubled
        r.core1_valid = (c.core1 >= 3'h3);  // same encoding as core0
        r.core1_x2 = r.core1_valid ? {5'h00, c.core1} : 8'h00;  // core ratio doubled
        r.mem_mult = MEM_TBL[c.memory];  // data rate multiplier
        r.sync_mode = (c.memory == 3'h7);  // top code means synchronous
        return r;
    endfunction

    task automatic cmp_val(input string what, input logic [35:0] ex, input logic [35:0] got);
        checks_done++;
        if (got !== ex) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, ex, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic ex, input logic got);
        checks_done++;
        if (got !== ex) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", what, ex, got);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // bounded wait so a dead slave cannot hang a transfer
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) cmp_flag("hreadyout", 1'b1, hreadyout);
    endtask

    // one single-word transfer; read data expectation queued at the data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] ex);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        dphase_rd <= ~wr;
        if (!wr) rd_q.push_back(ex);
        wait_ready();
        dphase_rd <= 1'b0;
    endtask

    // straps set while reset is low, then lock awaited within a bounded count
    task automatic do_reset(input strap_set_t c);
        int n;
        hresetn <= 1'b0;
        codes <= c;
        repeat (4) @(posedge hclk);
        cmp_val("ratios in reset", 36'h0, ratios);  // cleared before capture
        cmp_flag("straps_locked in reset", 1'b0, straps_locked);  // no lock yet
        rat_q.push_back(decode(c));
        hresetn <= 1'b1;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (straps_locked !== 1'b1 && n < 10);
        cmp_flag("straps_locked", 1'b1, straps_locked);  // lock inside the window
    endtask

    // --------
    // clock, watchdog and result monitor
    // --------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // a full run needs about 350 cycles; over fifty times that means a hang
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        results();
    end

    // values seen at the edge are those that stood during the cycle before
    always @(posedge hclk) begin
        if (dphase_rd === 1'b1 && hreadyout === 1'b1 && rd_q.size() > 0) begin
            cmp_val("hrdata", {4'h0, rd_q.pop_front()}, {4'h0, hrdata});  // read path
            cmp_flag("hresp", 1'b0, hresp);  // every read answered okay
        end
        if (straps_locked === 1'b1 && prev_lock !== 1'b1 && rat_q.size() > 0) begin
            cmp_val("ratios", rat_q.pop_front(), ratios);  // decoded set
        end
        prev_lock = straps_locked;
    end

    // --------
    // main sequence: every code of every strap group, one reset each
    // --------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        codes = '0;
        dphase_rd = 1'b0;
        lfsr_s = 16'h005F;
        n_fail = 0;
        checks_done = 0;
        for (int i = 0; i < 8; i++) begin
            // core1 runs the codes backwards so the two cores always differ
            s = '{3'(i), 3'(i), 3'(7 - i), 3'(i)};
            e = decode(s);
            @(posedge hclk);
            do_reset(s);
            cmp_flag("mem0_sync_mode", e.sync_mode, mem0_sync_mode);  // sync choice
            cmp_flag("mem1_sync_mode", e.sync_mode, mem1_sync_mode);  // same mode
            cmp_flag("mem_pll_select", ~e.sync_mode, mem_pll_select);  // own pll
            cmp_flag("mem_bus_clk_div2", 1'b1, mem_bus_clk_div2);  // halved clock
            cmp_flag("core1_clk_enable", 1'b1, core1_clk_enable);  // own core clock
            ahb(1'b0, 32'h0, 32'h0, {20'h0, s.platform, s.core0, s.core1, s.memory});
            ahb(1'b0, 32'h4, 32'h0, {23'h0, e.plat_valid, e.plat_mult});
            ahb(1'b0, 32'h8, 32'h0, {14'h0, e.core1_valid, e.core0_valid, e.core1_x2, e.core0_x2});
            ahb(1'b0, 32'hC, 32'h0, {22'h0, 1'b1, e.sync_mode, e.mem_mult});
            ahb(1'b0, 32'h10, 32'h0, 32'h3);
            ahb(1'b0, 32'h20, 32'h0, 32'h0);
            wd = rnd();
            ahb(1'b1, 32'h10, wd, 32'h0);
            ahb(1'b1, 32'h4, rnd(), 32'h0);
            ahb(1'b0, 32'h4, 32'h0, {23'h0, e.plat_valid, e.plat_mult});
            cmp_flag("core1_clk_enable", wd[0], core1_clk_enable);  // software gate
            cmp_flag("mem_bus_clk_div2", wd[1], mem_bus_clk_div2);  // divider gate
            // straps wander after lock; the captured set must not follow
            wd = rnd();
            codes <= wd[11:0];
            repeat (12) @(posedge hclk);
            cmp_val("ratios held", e, ratios);  // capture is once per reset
        end
        results();
    end
endmodule

// >>> tb/strap_board_model.sv
// board strap model: resistors that hold each strap group at a chosen code
// assumes the bench picks the codes and keeps them steady across reset release
module strap_board_model
    import strap_decoder_pkg::*;
(
    input strap_decoder_pkg::strap_set_t codes,
    output strap_decoder_pkg::strap_set_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    import strap_decoder_pkg::*;

    // --------
    // strap resistors
    // --------
    // every strap is pulled at all times, so no pin floats at power-up
    assign pins = codes;
    // the board also owns the reference clocks; no frequency is modelled here, so the
    // async data rate, bus clock and speed grade limits rest with the board alone
endmodule
